// ### common/dsf_pkg.sv
package dsf_pkg;

   localparam logic [7:0] DRIVER_STATUS_WORD_ADDR = 8'h6f;

   localparam int STANDSTILL_BIT     = 31;
   localparam int CHOPPER_MODE_BIT   = 30;
   localparam int SCALE_LSB          = 16;
   localparam int SCALE_WIDTH        = 5;
   localparam int TEMP_LSB           = 8;
   localparam int OPEN_LOAD_LSB      = 6;
   localparam int LOWSIDE_SHORT_LSB  = 4;
   localparam int GROUND_SHORT_LSB   = 2;
   localparam int THERMAL_SHUT_BIT   = 1;
   localparam int THERMAL_WARN_BIT   = 0;

   localparam int STANDSTILL_CYCLES  = 1 << 20;

   localparam logic [31:0] STATUS_RESET_VALUE = 32'h0000_0000;

   // Short flags of one chopper mode: bit 1 is phase B, bit 0 is phase A.
   typedef struct packed {
      logic [1:0] lowside;
      logic [1:0] ground;
   } dsf_short_s;

   // Raw indications from the analog and chopper blocks.
   typedef struct packed {
      logic       step_pulse;
      logic       quiet_mode;
      logic [4:0] current_scale;
      logic [3:0] temp_comp;
      logic [1:0] open_load;
      logic [1:0] lowside_short;
      logic [1:0] ground_short;
      logic       thermal_shutdown;
      logic       thermal_warning;
   } dsf_sense_s;

endpackage : dsf_pkg

// ### design/dsf_sync.sv
`timescale 1ns/1ns
module dsf_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } dsf_sync_state_s;

   dsf_sync_state_s state;
   dsf_sync_state_s next_state;

   initial
   begin
      if (WIDTH < 1)
      begin
         $error("dsf_sync: WIDTH must be at least 1.");
      end
   end

   always_comb
   begin
      next_state        = state;
      next_state.stage1 = async_in;
      next_state.stage2 = state.stage1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state <= '0;
      end
      else if (clk_en)
      begin
         state <= next_state;
      end
   end

   assign sync_out = state.stage2;
endmodule : dsf_sync

// ### design/dsf_standstill.sv
`timescale 1ns/1ns
module dsf_standstill #(
   parameter int CYCLES = dsf_pkg::STANDSTILL_CYCLES
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic clk_en,
   input  wire logic step_seen,
   output logic      standstill
);
   import dsf_pkg::*;

   localparam int CW = $clog2(CYCLES + 1);

   typedef struct packed {
      logic [CW-1:0] count;
      logic          flag;
   } dsf_stst_state_s;

   dsf_stst_state_s state;
   dsf_stst_state_s next_state;

   initial
   begin
      if (CYCLES < 2)
      begin
         $error("dsf_standstill: CYCLES must be at least 2.");
      end
   end

   // The count restarts on every step and saturates once the flag is up.
   always_comb
   begin
      next_state = state;
      if (step_seen)
      begin
         next_state.count = '0;
         next_state.flag  = 1'b0;
      end
      else if (!state.flag)
      begin
         next_state.count = state.count + CW'(1);
         if (state.count == CW'(CYCLES - 1))
         begin
            next_state.flag = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state <= '0;
      end
      else if (clk_en)
      begin
         state <= next_state;
      end
   end

   assign standstill = state.flag;
endmodule : dsf_standstill

// ### design/dsf_driver_status.sv
// Summary of operation
// - Bit 31 rises once 2^20 clocks have passed since the last step pulse.
// - Bit 30 reads 1 in the quiet voltage-mode chopper, 0 in the current one.
// - Bits 20 to 16 return the current scale that is applied right now.
// - Bits 11 to 8 read the 157, 150, 143 and 120 degree comparators.
// - Bit 7 shows open load on phase B and bit 6 on phase A.
// - Open-load flags only report and never disable the bridge.
// - Bits 5 and 4 latch low-side shorts on B and A and disable the driver while that chopper mode is active.
// - Bits 3 and 2 latch ground shorts on B and A and disable the driver while that chopper mode is active.
// - Short flags hold until the off time is 0 or the enable pin is high.
// - Short flags are kept apart for each of the two chopper modes.
// - Bit 1 reports thermal shutdown and disables both bridges.
// - After shutdown the bridges stay off until the pre-warning clears.
// - Bit 0 is set while the pre-warning threshold is exceeded.
// - Thermal shutdown and pre-warning are single flags for both bridges.
`timescale 1ns/1ns
module dsf_driver_status #(
   parameter int STANDSTILL_CYCLES = dsf_pkg::STANDSTILL_CYCLES
) (
   input  wire logic                sys_clk,
   input  wire logic                rst,
   input  wire logic                clk_en,
   input  wire dsf_pkg::dsf_sense_s sense,
   input  wire logic                enable_low_pin,
   input  wire logic [3:0]          chopper_off_time,
   input  wire logic                rd_en,
   input  wire logic [7:0]          rd_addr,
   output logic      [31:0]         rd_data,
   output logic                     rd_valid,
   output logic                     bridge_enable,
   output logic      [31:0]         driver_status_word
);
   import dsf_pkg::*;

   localparam int SENSE_W = $bits(dsf_sense_s);

   typedef struct packed {
      dsf_short_s  quiet_shorts;
      dsf_short_s  current_shorts;
      logic        thermal_hold;
      logic        step_prev;
      logic        bridge_on;
      logic [31:0] status;
      logic [31:0] rdata;
      logic        rvalid;
   } dsf_top_state_s;

   dsf_top_state_s state;
   dsf_top_state_s next_state;

   dsf_sense_s       sense_s;
   logic [SENSE_W:0] sync_out;
   logic             enable_low_s;
   logic             standstill;
   logic             step_seen;
   logic             driver_off;
   dsf_short_s       active_shorts;
   dsf_short_s       new_shorts;

   initial
   begin
      if (STANDSTILL_CYCLES < 2)
      begin
         $error("dsf_driver_status: STANDSTILL_CYCLES must be at least 2.");
      end
   end

   // Sense lines and the enable pin come from outside this clock domain.
   dsf_sync #(
      .WIDTH(SENSE_W + 1)
   ) u_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .clk_en   (clk_en),
      .async_in ({enable_low_pin, sense}),
      .sync_out (sync_out)
   );

   assign sense_s      = dsf_sense_s'(sync_out[SENSE_W-1:0]);
   assign enable_low_s = sync_out[SENSE_W];
   assign step_seen    = sense_s.step_pulse & ~state.step_prev;

   dsf_standstill #(
      .CYCLES(STANDSTILL_CYCLES)
   ) u_standstill (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .clk_en     (clk_en),
      .step_seen  (step_seen),
      .standstill (standstill)
   );

   // Disabling the driver is the only way to release latched shorts.
   assign driver_off = enable_low_s | (chopper_off_time == 4'h0);

   always_comb
   begin
      new_shorts.lowside = sense_s.lowside_short;
      new_shorts.ground  = sense_s.ground_short;
   end

   always_comb
   begin
      next_state           = state;
      next_state.step_prev = sense_s.step_pulse;

      // Each chopper mode keeps its own copy of the short flags.
      if (driver_off)
      begin
         next_state.quiet_shorts   = '0;
         next_state.current_shorts = '0;
      end
      else if (sense_s.quiet_mode)
      begin
         next_state.quiet_shorts = state.quiet_shorts | new_shorts;
      end
      else
      begin
         next_state.current_shorts =
            state.current_shorts | new_shorts;
      end

      // Shutdown holds until the pre-warning comparator has also dropped.
      if (sense_s.thermal_shutdown)
      begin
         next_state.thermal_hold = 1'b1;
      end
      else if (!sense_s.thermal_warning)
      begin
         next_state.thermal_hold = 1'b0;
      end

      active_shorts = sense_s.quiet_mode ? next_state.quiet_shorts
                                         : next_state.current_shorts;

      // Open load is deliberately absent from this term.
      next_state.bridge_on = !driver_off
                             && (active_shorts == '0)
                             && !next_state.thermal_hold;

      next_state.status = STATUS_RESET_VALUE;
      next_state.status[STANDSTILL_BIT]   = standstill;
      next_state.status[CHOPPER_MODE_BIT] = sense_s.quiet_mode;
      next_state.status[SCALE_LSB +: SCALE_WIDTH] =
         sense_s.current_scale;
      next_state.status[TEMP_LSB +: 4]      = sense_s.temp_comp;
      next_state.status[OPEN_LOAD_LSB +: 2] = sense_s.open_load;
      next_state.status[LOWSIDE_SHORT_LSB +: 2] =
         active_shorts.lowside;
      next_state.status[GROUND_SHORT_LSB +: 2] =
         active_shorts.ground;
      next_state.status[THERMAL_SHUT_BIT] =
         sense_s.thermal_shutdown;
      next_state.status[THERMAL_WARN_BIT] =
         sense_s.thermal_warning;

      // A read only copies the word; nothing is cleared by it.
      next_state.rvalid = rd_en;
      if (rd_en && rd_addr == DRIVER_STATUS_WORD_ADDR)
      begin
         next_state.rdata = state.status;
      end
      else if (rd_en)
      begin
         next_state.rdata = '0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state <= '0;
      end
      else if (clk_en)
      begin
         state <= next_state;
      end
   end

   assign rd_data            = state.rdata;
   assign rd_valid           = state.rvalid;
   assign bridge_enable      = state.bridge_on;
   assign driver_status_word = state.status;
endmodule : dsf_driver_status

// ### verif/dsf_driver_status_props.sv
`timescale 1ns/1ns
module dsf_driver_status_props #(
   parameter int STANDSTILL_CYCLES = dsf_pkg::STANDSTILL_CYCLES
) (
   input wire logic                sys_clk,
   input wire logic                rst,
   input wire logic                clk_en,
   input wire dsf_pkg::dsf_sense_s sense,
   input wire logic                enable_low_pin,
   input wire logic [3:0]          chopper_off_time,
   input wire logic                rd_en,
   input wire logic [7:0]          rd_addr,
   input wire logic [31:0]         rd_data,
   input wire logic                rd_valid,
   input wire logic                bridge_enable,
   input wire logic [31:0]         driver_status_word
);
   import dsf_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [31:0] w;
   assign w = driver_status_word;
   logic hit;
   assign hit = rd_en && clk_en && rd_addr == DRIVER_STATUS_WORD_ADDR;
   property p_valid; rd_en && clk_en |=> rd_valid; endproperty
   a_valid: assert property (p_valid)
      else $error("read not answered");
   property p_data; hit ##1 $stable(w) |-> rd_data == w; endproperty
   a_data: assert property (p_data)
      else $error("read data differs from status");
   property p_unmap;
      rd_en && clk_en && rd_addr != DRIVER_STATUS_WORD_ADDR |=> rd_data == 0;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped read not zero");
   property p_rsvd; w[29:21] == 9'h0 && w[15:12] == 4'h0; endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved bits set");
   property p_short; (|w[5:2]) ##1 $stable(w[30]) |-> !bridge_enable;
   endproperty
   a_short: assert property (p_short)
      else $error("bridge on with short");
   property p_once; clk_en && !rd_en |=> !rd_valid; endproperty
   a_once: assert property (p_once)
      else $error("read answered more than once");
   property p_ot; w[1] |-> !bridge_enable; endproperty
   a_ot: assert property (p_ot)
      else $error("bridge on in shutdown");
   property p_hold; ($fell(w[1]) && w[0]) ##1 w[0] |-> !bridge_enable;
   endproperty
   a_hold: assert property (p_hold)
      else $error("bridge on before warning clears");
   property p_stand; $rose(sense.step_pulse) |-> ##[1:6] !w[31]; endproperty
   a_stand: assert property (p_stand)
      else $error("standstill kept after step");
   c_read: cover property (rd_valid && rd_data != 0);
   c_short: cover property (|w[5:2]);
   c_ot: cover property (w[1]);
endmodule : dsf_driver_status_props

// ### verif/dsf_driver_status_test.sv
`timescale 1ns/1ns
module dsf_driver_status_test;
   import dsf_pkg::*;
   localparam int P = 16;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        clk_en = 1'b1;
   dsf_sense_s  sense = '0;
   logic        enable_low_pin = 1'b0;
   logic [3:0]  chopper_off_time = 4'h3;
   logic        rd_en = 1'b0;
   logic [7:0]  rd_addr = 8'h00;
   logic [31:0] rd_data;
   logic        rd_valid;
   logic        bridge_enable;
   logic [31:0] driver_status_word;
   int          n_mismatch = 0;
   int          check_count = 0;
   int          cycles = 0;
   dsf_driver_status #(.STANDSTILL_CYCLES(P)) uut (
      .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .sense(sense),
      .enable_low_pin(enable_low_pin), .chopper_off_time(chopper_off_time),
      .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
      .rd_valid(rd_valid), .bridge_enable(bridge_enable),
      .driver_status_word(driver_status_word));
   initial
   begin
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_of_test
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         n_mismatch++;
         end_of_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick
   task automatic put(input dsf_sense_s s);
      @(posedge sys_clk);
      sense <= s;
      tick(6);
   endtask : put
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      rd_en <= 1'b1;
      rd_addr <= a;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      @(posedge sys_clk);
      chk("rd_valid", 32'h1, {31'h0, rd_valid});
      chk("rd_data", e, rd_data);
   endtask : rd
   function automatic logic [31:0] wd(input dsf_sense_s s, logic [3:0] sh);
      return {1'b1, s.quiet_mode, 9'h0, s.current_scale, 4'h0, s.temp_comp,
              s.open_load, sh, s.thermal_shutdown, s.thermal_warning};
   endfunction : wd
   task automatic br(input logic e);
      chk("bridge_enable", {31'h0, e}, {31'h0, bridge_enable});
   endtask : br
   initial
   begin
      dsf_sense_s s;
      dsf_sense_s f;
      s = '0;
      tick(8);
      rst <= 1'b0;
      s.step_pulse = 1'b1;
      put(s);
      chk("standstill", 32'h0, {31'h0, driver_status_word[31]});
      s = '{quiet_mode: 1'b1, current_scale: 5'h15, temp_comp: 4'ha,
            open_load: 2'b10, thermal_warning: 1'b1, default: '0};
      put(s);
      tick(P);
      rd(8'h6f, wd(s, 4'h0));
      br(1'b1);
      for (int i = 0; i < 4; i++)
      begin
         s.temp_comp = 4'h1 << i;
         put(s);
         rd(8'h6f, wd(s, 4'h0));
      end
      s.step_pulse = 1'b1;
      put(s);
      chk("moving", 32'h0, {31'h0, driver_status_word[31]});
      chk("open_load", 32'h2, {30'h0, driver_status_word[7:6]});
      s.step_pulse = 1'b0;
      put(s);
      rd(8'h6e, 32'h0);
      s.lowside_short = 2'b01;
      put(s);
      s.lowside_short = 2'b00;
      put(s);
      rd(8'h6f, wd(s, 4'h4));
      br(1'b0);
      s.quiet_mode = 1'b0;
      put(s);
      rd(8'h6f, wd(s, 4'h0));
      s.quiet_mode = 1'b1;
      put(s);
      rd(8'h6f, wd(s, 4'h4));
      chopper_off_time <= 4'h0;
      tick(6);
      rd(8'h6f, wd(s, 4'h0));
      chopper_off_time <= 4'h3;
      s.ground_short = 2'b10;
      put(s);
      s.ground_short = 2'b00;
      put(s);
      rd(8'h6f, wd(s, 4'h2));
      enable_low_pin <= 1'b1;
      tick(6);
      rd(8'h6f, wd(s, 4'h0));
      enable_low_pin <= 1'b0;
      tick(6);
      br(1'b1);
      s.thermal_shutdown = 1'b1;
      put(s);
      rd(8'h6f, wd(s, 4'h0));
      br(1'b0);
      s.thermal_shutdown = 1'b0;
      put(s);
      br(1'b0);
      s.thermal_warning = 1'b0;
      put(s);
      br(1'b1);
      f = s;
      clk_en <= 1'b0;
      s.current_scale = 5'h0a;
      put(s);
      chk("frozen", wd(f, 4'h0), driver_status_word);
      clk_en <= 1'b1;
      tick(6);
      chk("scale", wd(s, 4'h0), driver_status_word);
      rst <= 1'b1;
      tick(2);
      chk("reset", STATUS_RESET_VALUE, driver_status_word);
      rst <= 1'b0;
      end_of_test();
   end
endmodule : dsf_driver_status_test
bind dsf_driver_status dsf_driver_status_props #(
   .STANDSTILL_CYCLES(STANDSTILL_CYCLES)) u_props (
   .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .sense(sense),
   .enable_low_pin(enable_low_pin), .chopper_off_time(chopper_off_time),
   .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
   .rd_valid(rd_valid), .bridge_enable(bridge_enable),
   .driver_status_word(driver_status_word));
